/* verilog/sstc_ctrl.sv */
/*
 * sstc_ctrl: per-axis safe stop one sequencer with torque cutoff.
 * assumes synchronous inputs, fieldbus writes as one-cycle strobes.
 */
// Summary of operation
// - instance active goes 1 on trigger
// - active returns 0 when cutoff engages
// - several active instances use fastest deceleration
// - fieldbus mode: no own deceleration, rate ignored
// - not stopped at timeout forces cutoff
// - timed variant if reduced or unmonitored
// - ramp variant when monitoring enabled and not reduced
// - timed states 0, 1, 4
// - ramp states 0 to 5
// - mode 0 decelerates at instance rate
// - fieldbus mode flags trigger at 50EFh
// - cutoff flag 1 at 0 V inputs
// - report enable gates fault when enabled
// - report enable and cutoff raise warning
// - temperature flag 1 when temperature ok
// - per-axis config enable at 3100h 02h/03h
// - hold brake keeps power for delay
// - dynamic brake applies with cutoff, no delay
// - default deceleration 10000 rpm/s
// - brake delay 1 to 60000 ms, default 100
`timescale 1ns/1ps
module sstc_ctrl
	import sstc_pkg::*;
#(
	parameter int unsigned N_INST = 2,
	parameter int unsigned DIV    = CYC_PER_MS
) (
	input  wire logic              i_clk_sys,       // system clock
	input  wire logic              i_resetn,        // async reset, low
	input  wire logic [N_INST-1:0] i_stop_req,      // safe input / bus stop
	input  wire logic [N_INST-1:0] i_stop_mode,     // 0 drive, 1 bus
	input  wire logic [31:0]       i_decel_wdata,   // rate write data
	input  wire logic [N_INST-1:0] i_decel_we,      // rate write strobes
	input  wire logic [15:0]       i_stop_time_ms,  // stop to cutoff time
	input  wire logic              i_reduced_var,   // reduced safety variant
	input  wire logic              i_monitor_en,    // decel/vel monitoring
	input  wire logic              i_vel_fault,     // ramp monitor violated
	input  wire logic              i_standstill,    // axis at rest
	input  wire logic              i_axis_enabled,  // axis enabled
	input  wire logic              i_cutoff_in_hi,  // cutoff inputs at 24 V
	input  wire logic              i_temp_ok,       // monitor temp in range
	input  wire logic              i_report_en,     // fault report setting
	input  wire logic [1:0]        i_brake_cfg,     // 0 none,1 hold,2 dyn
	input  wire logic [15:0]       i_brake_dly_ms,  // brake hold delay
	input  wire logic              i_brake_dly_we,  // delay write strobe
	input  wire logic [15:0]       i_od_index,      // object index
	input  wire logic [7:0]        i_od_sub,        // object subindex
	input  wire logic [7:0]        i_od_wdata,      // object write data
	input  wire logic              i_od_we,         // object write
	output logic [7:0]             o_od_rdata,      // object read data
	output logic [N_INST-1:0]      o_stop_active,   // instance active
	output logic [2:0]             o_stop_state,    // sequence state code
	output logic                   o_decel_en,      // own ramp running
	output logic [31:0]            o_decel_rate,    // chosen rate
	output logic                   o_cutoff,        // cut torque
	output logic                   o_brake_apply,   // apply brake
	output logic                   o_cutoff_active, // cutoff flag
	output logic                   o_cutoff_fault,  // cutoff fault
	output logic                   o_cutoff_warn,   // cutoff warning
	output logic                   o_temp_ok        // temp flag
);
	// ************************************************************
	// tick and configuration
	// ************************************************************
	logic                  tick;
	sstc_state_t           state_q;
	logic [31:0]           rate_q [N_INST];
	logic [15:0]           brake_dly_q;
	logic [15:0]           stop_cnt_q;
	logic [15:0]           brake_cnt_q;
	logic [7:0]            cfg_en_q [2];
	logic [N_INST-1:0]     trig_flag_q;
	logic                  timed;
	logic                  timeout;
	logic                  any_req;
	logic [31:0]           best_rate;
	logic                  any_drive;
	logic                  cut_now;

	sstc_ms_tick #(
		.DIV (DIV)
	) u_tick (
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.o_tick    (tick)
	);

	assign timed   = i_reduced_var | ~i_monitor_en;
	assign any_req = |i_stop_req;
	assign timeout = (stop_cnt_q >= i_stop_time_ms);

	// per-instance rate registers, default 10000 rpm/s
	generate
		for (genvar g = 0; g < N_INST; g++) begin : g_rate
			always_ff @(posedge i_clk_sys or negedge i_resetn) begin
				if (!i_resetn) begin
					rate_q[g] <= DECEL_RATE_DEF;
				end else if (i_decel_we[g]) begin
					rate_q[g] <= i_decel_wdata;
				end
			end
		end
	endgenerate

	// out-of-range writes keep the previous delay
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			brake_dly_q <= BRAKE_DELAY_DEF;
		end else if (i_brake_dly_we && i_brake_dly_ms >= BRAKE_DELAY_MIN &&
				i_brake_dly_ms <= BRAKE_DELAY_MAX) begin
			brake_dly_q <= i_brake_dly_ms;
		end
	end

	// ************************************************************
	// deceleration choice
	// ************************************************************
	always_comb begin
		best_rate = 32'h00000000;
		any_drive = 1'b0;
		for (int i = 0; i < N_INST; i++) begin
			if (o_stop_active[i] && i_stop_mode[i] == MODE_DRIVE) begin
				any_drive = 1'b1;
				if (rate_q[i] > best_rate) begin
					best_rate = rate_q[i];
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_decel_en   <= 1'b0;
			o_decel_rate <= 32'h00000000;
		end else begin
			// bus-mode instances are left out of any_drive above: no own ramp
			o_decel_en   <= any_drive;
			o_decel_rate <= best_rate;
		end
	end

	// ************************************************************
	// sequence
	// ************************************************************
	assign cut_now = (state_q != S_IDLE) && (state_q != S_CUT) &&
		(timeout || state_q == S_REACH);

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= S_IDLE;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (any_req) begin
						state_q <= S_DELAY;
					end
				end
				S_DELAY: begin
					if (cut_now) begin
						state_q <= S_CUT;
					end else if (!timed) begin
						state_q <= S_MON;
					end
				end
				S_MON: begin
					if (i_vel_fault) begin
						state_q <= S_CUT;
					end else if (cut_now) begin
						state_q <= S_CUT;
					end else if (i_standstill) begin
						state_q <= S_REACH;
					end
				end
				S_REACH: begin
					if (cut_now) begin
						state_q <= S_CUT;
					end
				end
				S_CUT: begin
					if (!any_req) begin
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// millisecond timer begins at the trigger
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			stop_cnt_q <= 16'h0000;
		end else if (state_q == S_IDLE) begin
			stop_cnt_q <= 16'h0000;
		end else if (tick && stop_cnt_q != 16'hffff) begin
			stop_cnt_q <= stop_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_stop_state <= ST_IDLE;
		end else begin
			unique case (state_q)
				S_IDLE:  o_stop_state <= ST_IDLE;
				S_DELAY: o_stop_state <= ST_DELAY;
				S_MON:   o_stop_state <= i_vel_fault ? ST_FAULT :
						ST_NOT_REACH;
				S_REACH: o_stop_state <= ST_REACHED;
				S_CUT:   o_stop_state <= ST_CUTOFF;
				default: o_stop_state <= ST_IDLE;
			endcase
		end
	end

	// active rises with the trigger, falls once cutoff is entered
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_stop_active <= '0;
		end else if (state_q == S_CUT || cut_now) begin
			o_stop_active <= '0;
		end else begin
			o_stop_active <= o_stop_active | i_stop_req;
		end
	end

	// bus-mode trigger flag, readable at the status object
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			trig_flag_q <= '0;
		end else begin
			trig_flag_q <= i_stop_req & i_stop_mode;
		end
	end

	// ************************************************************
	// brake and cutoff
	// ************************************************************
	// hold brake: power stays on after cutoff request for the delay
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			brake_cnt_q <= 16'h0000;
		end else if (state_q != S_CUT) begin
			brake_cnt_q <= 16'h0000;
		end else if (tick && brake_cnt_q < brake_dly_q) begin
			brake_cnt_q <= brake_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_cutoff      <= 1'b0;
			o_brake_apply <= 1'b0;
		end else if (state_q != S_CUT) begin
			o_cutoff      <= 1'b0;
			o_brake_apply <= 1'b0;
		end else if (i_brake_cfg == BRAKE_HOLD) begin
			o_brake_apply <= 1'b1;
			// the delay should cover the brake apply time
			o_cutoff      <= (brake_cnt_q >= brake_dly_q);
		end else begin
			o_brake_apply <= (i_brake_cfg == BRAKE_DYN);
			o_cutoff      <= 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_cutoff_active <= 1'b0;
			o_cutoff_fault  <= 1'b0;
			o_cutoff_warn   <= 1'b0;
			o_temp_ok       <= 1'b0;
		end else begin
			o_cutoff_active <= ~i_cutoff_in_hi;
			o_cutoff_warn   <= i_report_en & ~i_cutoff_in_hi;
			o_temp_ok       <= i_temp_ok;
			if (!i_report_en) begin
				o_cutoff_fault <= 1'b0;
			end else if (~i_cutoff_in_hi && i_axis_enabled) begin
				o_cutoff_fault <= 1'b1;
			end else if (i_cutoff_in_hi) begin
				o_cutoff_fault <= 1'b0;
			end
		end
	end

	// ************************************************************
	// object dictionary
	// ************************************************************
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_en_q[0] <= AXIS_CFG_EN_RESET;
			cfg_en_q[1] <= AXIS_CFG_EN_RESET;
		end else if (i_od_we && i_od_index == OD_AXIS_SAFETY_CFG_ENABLE) begin
			if (i_od_sub == SUB_AXIS1_CFG_EN) begin
				cfg_en_q[0] <= i_od_wdata;
			end
			if (i_od_sub == SUB_AXIS2_CFG_EN) begin
				cfg_en_q[1] <= i_od_wdata;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_od_rdata <= 8'h00;
		end else if (i_od_index == OD_AXIS_SAFETY_CFG_ENABLE &&
				i_od_sub == SUB_AXIS1_CFG_EN) begin
			o_od_rdata <= cfg_en_q[0];
		end else if (i_od_index == OD_AXIS_SAFETY_CFG_ENABLE &&
				i_od_sub == SUB_AXIS2_CFG_EN) begin
			o_od_rdata <= cfg_en_q[1];
		end else if (i_od_index == OD_STOP_TRIG_STATUS) begin
			o_od_rdata <= 8'(trig_flag_q);
		end else begin
			o_od_rdata <= 8'h00;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_active_rise: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(state_q == S_IDLE && i_stop_req[0]) |=> o_stop_active[0])
		else $error("active not set on trigger");
	a_active_drop: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(state_q == S_CUT) |=> o_stop_active == '0)
		else $error("active held in cutoff");
	a_timeout_cut: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(state_q == S_DELAY && timeout) |=> state_q == S_CUT)
		else $error("timeout did not force cutoff");
	a_cut_code: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(state_q == S_CUT) |=> o_stop_state == ST_CUTOFF)
		else $error("cutoff code wrong");
	a_bus_no_ramp: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(&i_stop_mode) && $stable(i_stop_mode) |=> !o_decel_en)
		else $error("ramp in bus mode");
	a_sto_flag: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		1'b1 |=> o_cutoff_active == !$past(i_cutoff_in_hi))
		else $error("cutoff flag wrong");
	a_warn_gate: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		!i_report_en |=> !o_cutoff_warn && !o_cutoff_fault)
		else $error("report while disabled");
	a_dyn_brake: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(state_q == S_CUT && i_brake_cfg == BRAKE_DYN) |=>
		o_cutoff && o_brake_apply)
		else $error("dynamic brake not with cutoff");
	a_temp_flag: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		1'b1 |=> o_temp_ok == $past(i_temp_ok))
		else $error("temperature flag wrong");
	sequence s_reached;
		state_q == S_REACH;
	endsequence
	a_reach_cut: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		s_reached |=> state_q == S_CUT && o_stop_active == '0)
		else $error("standstill did not cut");
	a_fault_code: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(state_q == S_MON && i_vel_fault) |=> o_stop_state == ST_FAULT)
		else $error("fault code not shown");
endmodule

/* verilog/sstc_pkg.sv */
/*
 * sstc_pkg: constants shared by the safe stop / torque cutoff controller.
 * assumes a 10 MHz system clock and a 1 ms tick derived from it.
 */
package sstc_pkg;
	// ************************************************************
	// object dictionary
	// ************************************************************
	localparam logic [15:0] OD_AXIS_SAFETY_CFG_ENABLE = 16'h3100;
	localparam logic [7:0]  SUB_AXIS1_CFG_EN          = 8'h02;
	localparam logic [7:0]  SUB_AXIS2_CFG_EN          = 8'h03;
	localparam logic [15:0] OD_STOP_TRIG_STATUS       = 16'h50ef;
	localparam logic [7:0]  AXIS_CFG_EN_RESET         = 8'h01;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned CLK_HZ           = 10000000;
	localparam int unsigned TICK_MS          = 1;
	localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000 * TICK_MS;
	localparam logic [15:0] BRAKE_DELAY_DEF  = 16'h0064; // 100 ms
	localparam logic [15:0] BRAKE_DELAY_MIN  = 16'h0001;
	localparam logic [15:0] BRAKE_DELAY_MAX  = 16'hea60; // 60000 ms
	localparam logic [15:0] STOP_TIME_DEF    = 16'h03e8;
	localparam logic [31:0] DECEL_RATE_DEF   = 32'h00002710; // 10000 rpm/s

	// ************************************************************
	// reported codes
	// ************************************************************
	localparam logic [2:0] ST_IDLE      = 3'h0;
	localparam logic [2:0] ST_DELAY     = 3'h1;
	localparam logic [2:0] ST_NOT_REACH = 3'h2;
	localparam logic [2:0] ST_REACHED   = 3'h3;
	localparam logic [2:0] ST_CUTOFF    = 3'h4;
	localparam logic [2:0] ST_FAULT     = 3'h5;
	localparam logic       MODE_DRIVE   = 1'b0;
	localparam logic       MODE_BUS     = 1'b1;
	localparam logic [1:0] BRAKE_NONE   = 2'h0;
	localparam logic [1:0] BRAKE_HOLD   = 2'h1;
	localparam logic [1:0] BRAKE_DYN    = 2'h2;

	typedef enum logic [4:0] {
		S_IDLE   = 5'b00001,
		S_DELAY  = 5'b00010,
		S_MON    = 5'b00100,
		S_REACH  = 5'b01000,
		S_CUT    = 5'b10000
	} sstc_state_t;
endpackage

/* verilog/sstc_ms_tick.sv */
/*
 * sstc_ms_tick: one-cycle enable every millisecond.
 * assumes the single system clock; no other clocks exist.
 */
`timescale 1ns/1ps
module sstc_ms_tick
	import sstc_pkg::*;
#(
	parameter int unsigned DIV = CYC_PER_MS
) (
	input  wire logic i_clk_sys,  // system clock
	input  wire logic i_resetn,   // async reset, low
	output logic      o_tick      // 1 ms pulse
);
	logic [15:0] cnt_q;

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_q  <= 16'h0000;
			o_tick <= 1'b0;
		end else if (cnt_q == 16'(DIV - 1)) begin
			cnt_q  <= 16'h0000;
			o_tick <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 16'h0001;
			o_tick <= 1'b0;
		end
	end
endmodule

/* verif/sstc_far_side.sv */
/*
 * sstc_far_side: safe input sources and a fieldbus master that
 * brings the axis to rest when a stop is handed to the bus.
 * assumes the bench supplies the stop demands and a stop latency.
 */
`timescale 1ns/1ps
module sstc_far_side (
	input  wire logic        i_clk_sys,    // system clock
	input  wire logic [1:0]  i_cmd_req,    // stop demand per instance
	input  wire logic [1:0]  i_cmd_mode,   // 0 drive, 1 bus
	input  wire logic [15:0] i_rest_lat,   // cycles the master needs
	output logic [1:0]       o_stop_req,   // safe input levels
	output logic             o_standstill  // axis at rest
);
	// ****************************************************
	// master stop
	// ****************************************************
	int cnt;
	logic bus_stop;

	assign o_stop_req = i_cmd_req;
	assign bus_stop = (i_cmd_req & i_cmd_mode) != 2'h0;
	// rest is only reported while the master owns a stop
	always @(posedge i_clk_sys) begin
		if (!bus_stop)
			cnt <= 0;
		else if (cnt < i_rest_lat)
			cnt <= cnt + 1;
	end
	assign o_standstill = bus_stop && cnt >= i_rest_lat;
endmodule

/* verif/safe_stop_torque_cutoff_ctrl_test.sv */
/*
 * testbench: drives the stop sequencer through both variants,
 * brake handling, cutoff reporting and object access.
 * assumes DIV shortened to 10 cycles per millisecond.
 */
`timescale 1ns/1ps
module safe_stop_torque_cutoff_ctrl_test;
	import sstc_pkg::*;
	localparam int DV = 10;
	logic        clk, rstn, vel_f, axis_en, in_hi, temp_in, rep_en;
	logic        dly_we, od_we, red, mon, still;
	logic [1:0]  req, mode, dec_we, brk, act, sreq;
	logic [31:0] dec_wd, rate;
	logic [15:0] stime, dly, od_idx, lat;
	logic [7:0]  od_sub, od_wd, rdata;
	logic [2:0]  code;
	logic        dec_en, cut, bapp, cact, cflt, cwarn, tok;
	int          mismatches, samples_checked, n, odd, t;
	int          rate_m[2];

	sstc_far_side i_far (.i_clk_sys(clk), .i_cmd_req(req),
		.i_cmd_mode(mode), .i_rest_lat(lat), .o_stop_req(sreq),
		.o_standstill(still));
	sstc_ctrl #(.N_INST(2), .DIV(DV)) i_dut (.i_clk_sys(clk),
		.i_resetn(rstn), .i_stop_req(sreq), .i_stop_mode(mode),
		.i_decel_wdata(dec_wd), .i_decel_we(dec_we),
		.i_stop_time_ms(stime), .i_reduced_var(red),
		.i_monitor_en(mon), .i_vel_fault(vel_f),
		.i_standstill(still), .i_axis_enabled(axis_en),
		.i_cutoff_in_hi(in_hi), .i_temp_ok(temp_in),
		.i_report_en(rep_en), .i_brake_cfg(brk),
		.i_brake_dly_ms(dly), .i_brake_dly_we(dly_we),
		.i_od_index(od_idx), .i_od_sub(od_sub), .i_od_wdata(od_wd),
		.i_od_we(od_we), .o_od_rdata(rdata), .o_stop_active(act),
		.o_stop_state(code), .o_decel_en(dec_en), .o_decel_rate(rate),
		.o_cutoff(cut), .o_brake_apply(bapp), .o_cutoff_active(cact),
		.o_cutoff_fault(cflt), .o_cutoff_warn(cwarn), .o_temp_ok(tok));

	// ****************************************************
	// helpers
	// ****************************************************
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#10;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string s);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s got %0h", $time, s, got);
		end
	endtask
	task automatic od_chk(input logic [15:0] x, input logic [7:0] y, e);
		od_idx = x;
		od_sub = y;
		step(1);
		chk(rdata, e, "object read");
	endtask
	task automatic od_wr(input logic [15:0] x, input logic [7:0] y, d);
		od_idx = x;
		od_sub = y;
		od_wd = d;
		od_we = 1'b1;
		step(1);
		od_we = 1'b0;
	endtask
	task automatic dly_wr(input logic [15:0] v);
		dly = v;
		dly_we = 1'b1;
		step(1);
		dly_we = 1'b0;
		step(1);
	endtask
	// waits for cutoff; notes any ramp-only code seen meanwhile
	task automatic wait_cut();
		n = 0;
		odd = 0;
		while (cut !== 1'b1 && n < 2000) begin
			if (code === 3'h2 || code === 3'h3 || code === 3'h5)
				odd |= 1 << code;
			step(1);
			n++;
		end
	endtask
	function automatic logic [31:0] fastest(input logic [1:0] a, md);
		int q[$];
		for (int k = 0; k < 2; k++)
			if (a[k] && !md[k])
				q.push_back(rate_m[k]);
		q.sort();
		return (q.size() == 0) ? 32'h0 : q[q.size()-1];
	endfunction
	task automatic summarize();
		$display("mismatches=%0d samples_checked=%0d", mismatches,
			samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		summarize();
	end

	// ****************************************************
	// scenarios
	// ****************************************************
	initial begin
		{rstn, vel_f, axis_en, temp_in, dly_we, od_we, mon} = '0;
		{in_hi, rep_en, red} = 3'h7;
		{req, mode, dec_we, brk} = '0;
		{dec_wd, stime, dly, od_idx, od_sub, od_wd} = '0;
		lat = 16'hffff;
		rate_m = '{32'h2710, 32'h2710};
		mismatches = 0;
		samples_checked = 0;
		void'($urandom(45722));
		repeat (6) @(posedge clk);
		#10;
		rstn = 1'b1;
		step(2);
		chk(code, 3'h0, "idle code");
		chk(act, 2'h0, "idle active");
		chk(tok, 1'b0, "temp bad");
		temp_in = 1'b1;
		step(2);
		chk(tok, 1'b1, "temp ok");
		od_chk(16'h3100, 8'h02, 8'h01);
		od_wr(16'h3100, 8'h03, 8'h00);
		od_chk(16'h3100, 8'h03, 8'h00);
		od_chk(16'h3100, 8'h02, 8'h01);
		// timed variant even though monitoring is on
		mon = 1'b1;
		t = 2 + $urandom % 3;
		stime = t;
		req = 2'h1;
		step(1);
		chk(act, 2'h1, "active on trigger");
		step(1);
		chk(code, 3'h1, "delay code");
		chk(dec_en, 1'b1, "own ramp");
		chk(rate, 32'h2710, "default rate");
		wait_cut();
		n = n - (t - 1) * DV;
		chk(n >= 2 && n <= DV + 1, 1, "timeout");
		chk(odd, 0, "timed codes only");
		step(1);
		chk(act, 2'h0, "active drops");
		chk(code, 3'h4, "cutoff code");
		req = 2'h0;
		step(3);
		chk(code, 3'h0, "back idle");
		// random rates, fastest wins
		for (int k = 0; k < 2; k++) begin
			rate_m[k] = 1 + $urandom % 50000;
			dec_wd = rate_m[k];
			dec_we = 2'h1 << k;
			step(1);
			dec_we = 2'h0;
			step(1);
		end
		stime = 16'h0032;
		for (int k = 0; k < 3; k++) begin
			mode = (k == 0) ? 2'h0 : (k == 1) ? 2'h2 : 2'h3;
			req = 2'h3;
			step(3);
			chk(dec_en, k < 2, "ramp enable");
			if (k < 2)
				chk(rate, fastest(2'h3, mode), "chosen rate");
			else
				od_chk(16'h50ef, 8'h00, 8'h03);
			// the request stays set until cutoff, then drops
			wait_cut();
			req = 2'h0;
			step(3);
		end
		// ramp variant, master stops the axis early
		red = 1'b0;
		mode = 2'h1;
		lat = 16'h003c;
		stime = 16'h0014;
		req = 2'h1;
		step(2);
		od_chk(16'h50ef, 8'h00, 8'h01);
		wait_cut();
		chk(n < 15 * DV, 1, "early cutoff at rest");
		chk(odd, 32'hc, "ramp codes");
		step(1);
		chk(code, 3'h4, "ramp cutoff code");
		chk(act, 2'h0, "active drops early");
		req = 2'h0;
		lat = 16'hffff;
		step(3);
		chk(code, 3'h0, "ramp idle");
		// ramp monitor violation: fault code, then cutoff
		vel_f = 1'b1;
		req = 2'h1;
		step(3);
		chk(code, 3'h5, "fault reaction");
		step(1);
		chk(code, 3'h4, "fault cutoff code");
		vel_f = 1'b0;
		req = 2'h0;
		step(3);
		// cutoff inputs and reporting
		axis_en = 1'b1;
		in_hi = 1'b0;
		step(3);
		chk({cact, cflt, cwarn}, 3'h7, "cutoff reported");
		in_hi = 1'b1;
		step(3);
		chk({cact, cflt, cwarn}, 3'h0, "cutoff released");
		rep_en = 1'b0;
		in_hi = 1'b0;
		step(3);
		chk({cact, cflt, cwarn}, 3'h4, "reporting off");
		in_hi = 1'b1;
		rep_en = 1'b1;
		step(3);
		// hold brake: 2 ms, out-of-range writes refused
		red = 1'b1;
		mode = 2'h0;
		dly_wr(16'h0002);
		dly_wr(16'hea61);
		dly_wr(16'h0000);
		brk = 2'h1;
		stime = 16'h0002;
		req = 2'h1;
		n = 0;
		while (bapp !== 1'b1 && n < 2000) begin
			step(1);
			n++;
		end
		wait_cut();
		chk(n >= DV + 1 && n <= 2 * DV, 1, "hold delay");
		req = 2'h0;
		step(3);
		brk = 2'h2;
		req = 2'h1;
		wait_cut();
		chk(bapp, 1'b1, "brake with cutoff");
		req = 2'h0;
		step(3);
		summarize();
	end
endmodule
